// >>> logic/cmpm_port.sv
// Control memory controller with shared PHY register port and Avalon-MM register slave.
//
// Summary of operation
// - Share 32 data, 19 address lines with PHY.
// - Host command starts a PHY control cycle.
// - PHY chip select low during PHY cycle.
// - PHY direction high for read, low write.
// - PHY output enable low during PHY read.
// - Low PHY interrupt sets status flag.
// - PHY interrupt level readable as input.
// - PHY reset held 17 clocks after reset.
// - Soft reset write pulses PHY reset 17 clocks.
// - Four byte enables, OE, WE, four parity lines.
// - Memory up to 512K words of 32 bits.
// - Output enable low 20, high 16, repeating; forced high here during PHY cycles.
// - Reads while OE low, writes while high.
// - Byte enables select word, half or byte.
// - Even parity per byte lane, both directions.
// - Mode bit 15 enables read parity check.
// - Parity mismatch sets sticky status flag.
// - Write parity driven only on memory write strobes.
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`include "cmpm_regs.svh"
`default_nettype none
module cmpm_port #(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 32
) (
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  input  wire logic                 clk_en,
  input  wire logic [5:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  output logic      [ADDR_W-1:0]    cm_address_bus,
  input  wire logic [DATA_W-1:0]    cm_data_in,
  output logic      [DATA_W-1:0]    cm_data_out,
  output logic                      cm_data_oe,
  output logic      [3:0]           cm_byte_enable_n,
  output logic                      cm_output_enable_n,
  output logic                      cm_write_enable_n,
  input  wire logic [3:0]           cm_parity_in,
  output logic      [3:0]           cm_parity_out,
  output logic                      cm_parity_oe,
  output logic                      phy_chip_select_n,
  output logic                      phy_read_not_write,
  output logic                      phy_output_enable_n,
  input  wire logic                 phy_irq_n,
  output logic                      phy_reset_n
);
  import cmpm_pkg::*;

  // ==========================================================================
  // Helpers
  function automatic logic [3:0] lane_parity(input logic [31:0] d);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      p[i] = ^d[8*i +: 8];
    end
    return p;
  endfunction

  function automatic logic [3:0] width_lanes(input cmpm_width_t w, input logic [1:0] sel);
    logic [3:0] m;
    m = 4'h0;
    unique case (w)
      CMPM_W_WORD:    m = 4'hF;
      CMPM_W_HALF_LO: m = 4'h3;
      CMPM_W_HALF_HI: m = 4'hC;
      CMPM_W_BYTE:    m = 4'(4'h1 << sel);
    endcase
    return m;
  endfunction

  // ==========================================================================
  // Input synchronisers
  // Every pin input crosses two flops before any logic reads it; the interrupt
  // pair rests at the idle high level so that no false event follows reset.
  logic [1:0] irq_sync_r;
  logic [3:0] par_s1_r, par_s2_r;
  logic [31:0] dat_s1_r, dat_s2_r;

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      irq_sync_r <= 2'h3;
    else if (clk_en)
      irq_sync_r <= {irq_sync_r[0], phy_irq_n};
  end

  // Data and parity move together so that a lane and its parity bit stay aligned.
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      par_s1_r <= 4'h0;
      par_s2_r <= 4'h0;
      dat_s1_r <= 32'h0;
      dat_s2_r <= 32'h0;
    end
    else if (clk_en)
    begin
      par_s1_r <= cm_parity_in;
      par_s2_r <= par_s1_r;
      dat_s1_r <= 32'(cm_data_in);
      dat_s2_r <= dat_s1_r;
    end
  end

  // ==========================================================================
  // Output enable window timer
  localparam int WIN_CYC = `CMPM_OE_LOW_CYCLES + `CMPM_OE_HIGH_CYCLES;
  logic [5:0] win_cnt_r;
  logic       read_win;

  // The first counts of each period form the read window, the rest the write window.
  assign read_win = (win_cnt_r < 6'(`CMPM_OE_LOW_CYCLES));

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      win_cnt_r <= 6'h00;
    else if (clk_en)
      win_cnt_r <= (win_cnt_r == 6'(WIN_CYC - 1)) ? 6'h00 : 6'(win_cnt_r + 6'h01);
  end

  // ==========================================================================
  // PHY reset stretcher
  // The counter is loaded while reset is held and by a soft reset write, so the
  // PHY sees at least the required low time after either kind of reset.
  logic [4:0] rst_cnt_r;
  logic       soft_rst;

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      rst_cnt_r <= 5'(`CMPM_PHY_RESET_CYCLES);
    else if (clk_en)
    begin
      if (soft_rst)
        rst_cnt_r <= 5'(`CMPM_PHY_RESET_CYCLES);
      else if (rst_cnt_r != 5'h00)
        rst_cnt_r <= 5'(rst_cnt_r - 5'h01);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      phy_reset_n <= 1'b0;
    else if (clk_en)
      phy_reset_n <= !soft_rst && (rst_cnt_r == 5'h00);
  end

  // ==========================================================================
  // Registers and access sequencer
  logic [31:0]       mode_r;
  logic              irq_flag_r, par_flag_r;
  logic [ADDR_W-1:0] acc_addr_r;
  logic [31:0]       acc_data_r, acc_rdata_r;
  logic              acc_read_r, acc_phy_r;
  cmpm_width_t       acc_width_r;
  cmpm_state_t       state_r;
  logic [2:0]        step_r;
  logic              par_chk;
  logic              bus_wr, bus_rd, cmd_go;
  logic              mem_go, phy_on, clr_st;

  assign bus_wr = clk_en && avs_write && avs_waitrequest;
  assign bus_rd = clk_en && avs_read && avs_waitrequest;
  assign soft_rst = bus_wr && (avs_address == `CMPM_OFS_SOFT_RESET);
  assign cmd_go = bus_wr && (avs_address == `CMPM_OFS_ACCESS_CMD) && avs_writedata[`CMPM_CMD_START_BIT]
                  && (state_r == CMPM_ST_IDLE);
  // A memory access strobes only inside its own window and never in a window's last
  // cycle, so every turn of the shared data lines gets a quiet cycle before it.
  assign mem_go = (state_r == CMPM_ST_MEM) && (acc_read_r == read_win)
                  && (win_cnt_r != 6'(WIN_CYC - 1)) && (win_cnt_r != 6'(`CMPM_OE_LOW_CYCLES - 1));
  assign phy_on = (state_r == CMPM_ST_PHY);

  // Every request is answered one cycle after it is seen; read data is loaded at
  // that same edge and stands while waitrequest is low.
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end
    else if (clk_en)
    begin
      avs_waitrequest <= !(avs_waitrequest && (avs_read || avs_write));
      if (bus_rd)
      begin
        unique case (avs_address)
          `CMPM_OFS_GENERAL_MODE:  avs_readdata <= mode_r;
          `CMPM_OFS_GLOBAL_STATUS: avs_readdata <= 32'({!irq_sync_r[1], state_r != CMPM_ST_IDLE,
                                                        par_flag_r, irq_flag_r});
          `CMPM_OFS_ACCESS_ADDR:   avs_readdata <= 32'(acc_addr_r);
          `CMPM_OFS_ACCESS_DATA:   avs_readdata <= acc_data_r;
          `CMPM_OFS_ACCESS_RDATA:  avs_readdata <= acc_rdata_r;
          default:                 avs_readdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn || soft_rst)
      mode_r <= `CMPM_GMR_RESET;
    else if (bus_wr && avs_address == `CMPM_OFS_GENERAL_MODE)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (avs_byteenable[b])
          mode_r[8*b +: 8] <= avs_writedata[8*b +: 8];
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn || soft_rst)
    begin
      acc_addr_r <= '0;
      acc_data_r <= 32'h0;
    end
    else if (bus_wr && avs_address == `CMPM_OFS_ACCESS_ADDR)
      acc_addr_r <= avs_writedata[ADDR_W-1:0];
    else if (bus_wr && avs_address == `CMPM_OFS_ACCESS_DATA)
      acc_data_r <= avs_writedata;
  end

  // Status flags are sticky; a set in the clearing cycle wins.
  assign clr_st = bus_wr && (avs_address == `CMPM_OFS_GLOBAL_STATUS);

  always_ff @(posedge sys_clk)
  begin
    if (!resetn || soft_rst)
      irq_flag_r <= 1'b0;
    else if (clk_en)
      irq_flag_r <= !irq_sync_r[1] || (irq_flag_r && !(clr_st && avs_writedata[`CMPM_GSR_PHY_IRQ_BIT]));
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn || soft_rst)
      par_flag_r <= 1'b0;
    else if (clk_en)
      par_flag_r <= par_chk || (par_flag_r && !(clr_st && avs_writedata[`CMPM_GSR_PARITY_BIT]));
  end

  // The word strobed by a memory read reaches the second synchroniser stage at done step 2,
  // the edge that also loads it into the read data register, so only that edge is checked.
  assign par_chk = (state_r == CMPM_ST_DONE) && (step_r == 3'h2) && !acc_phy_r && acc_read_r
                   && mode_r[`CMPM_GMR_PARITY_BIT]
                   && ((lane_parity(dat_s2_r) ^ par_s2_r)
                       & width_lanes(acc_width_r, acc_addr_r[1:0])) != 4'h0;

  always_ff @(posedge sys_clk)
  begin
    if (!resetn || soft_rst)
    begin
      state_r     <= CMPM_ST_IDLE;
      step_r      <= 3'h0;
      acc_read_r  <= 1'b0;
      acc_phy_r   <= 1'b0;
      acc_width_r <= CMPM_W_WORD;
      acc_rdata_r <= 32'h0;
    end
    else if (clk_en)
    begin
      unique case (state_r)
        CMPM_ST_IDLE:
          if (cmd_go)
          begin
            acc_read_r  <= avs_writedata[`CMPM_CMD_READ_BIT];
            acc_phy_r   <= avs_writedata[`CMPM_CMD_PHY_BIT];
            acc_width_r <= cmpm_width_t'(avs_writedata[`CMPM_CMD_WIDTH_LSB +: 2]);
            state_r     <= avs_writedata[`CMPM_CMD_PHY_BIT] ? CMPM_ST_PHY : CMPM_ST_MEM;
            step_r      <= 3'h0;
          end
        CMPM_ST_MEM:
          if (mem_go)
          begin
            state_r <= CMPM_ST_DONE;
            step_r  <= 3'h0;
          end
        CMPM_ST_PHY:
          if (step_r == 3'(`CMPM_PHY_STROBE_CYCLES - 1))
          begin
            state_r <= CMPM_ST_DONE;
            step_r  <= 3'h0;
          end
          else
            step_r <= 3'(step_r + 3'h1);
        CMPM_ST_DONE:
          if (step_r == 3'h2)
          begin
            if (acc_read_r)
              acc_rdata_r <= dat_s2_r;
            state_r <= CMPM_ST_IDLE;
          end
          else
            step_r <= 3'(step_r + 3'h1);
      endcase
    end
  end

  // ==========================================================================
  // Pin drivers
  // Address, write data and write parity follow the access registers; the address lines
  // are always driven, data and parity only reach the lines while the matching output enable below is high.
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      cm_address_bus <= '0;
      cm_data_out    <= '0;
      cm_parity_out  <= 4'h0;
    end
    else if (clk_en)
    begin
      cm_address_bus <= acc_addr_r;
      cm_data_out    <= DATA_W'(acc_data_r);
      cm_parity_out  <= lane_parity(acc_data_r);
    end
  end

  // Memory strobes; the output enable keeps its rhythm even while no access is pending.
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      cm_output_enable_n <= 1'b1;
      cm_write_enable_n  <= 1'b1;
      cm_byte_enable_n   <= 4'hF;
      cm_data_oe         <= 1'b0;
      cm_parity_oe       <= 1'b0;
    end
    else if (clk_en)
    begin
      cm_output_enable_n <= phy_on ? 1'b1 : !read_win;
      cm_write_enable_n  <= !(mem_go && !acc_read_r);
      cm_byte_enable_n   <= mem_go ? ~width_lanes(acc_width_r, acc_addr_r[1:0]) : 4'hF;
      cm_data_oe         <= (mem_go || phy_on) && !acc_read_r;
      cm_parity_oe       <= mem_go && !acc_read_r;
    end
  end

  // PHY strobes; the direction line rests at read so that an idle PHY never sees a write.
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      phy_chip_select_n   <= 1'b1;
      phy_read_not_write  <= 1'b1;
      phy_output_enable_n <= 1'b1;
    end
    else if (clk_en)
    begin
      phy_chip_select_n   <= !phy_on;
      phy_read_not_write  <= phy_on ? acc_read_r : 1'b1;
      phy_output_enable_n <= !(phy_on && acc_read_r);
    end
  end
endmodule
`default_nettype wire

// >>> logic/cmpm_regs.svh
// Register offsets, field positions, reset values and timing counts of the control memory and PHY port.
`ifndef CMPM_REGS_SVH
`define CMPM_REGS_SVH
`define CMPM_OFS_GENERAL_MODE   6'h00
`define CMPM_OFS_GLOBAL_STATUS  6'h04
`define CMPM_OFS_SOFT_RESET     6'h08
`define CMPM_OFS_ACCESS_ADDR    6'h0C
`define CMPM_OFS_ACCESS_DATA    6'h10
`define CMPM_OFS_ACCESS_CMD     6'h14
`define CMPM_OFS_ACCESS_RDATA   6'h18
`define CMPM_GMR_PARITY_BIT     15
`define CMPM_GMR_RESET          32'h0000_0000
`define CMPM_GSR_PHY_IRQ_BIT    0
`define CMPM_GSR_PARITY_BIT     1
`define CMPM_GSR_BUSY_BIT       2
`define CMPM_GSR_PIN_LEVEL_BIT  3
`define CMPM_CMD_START_BIT      0
`define CMPM_CMD_READ_BIT       1
`define CMPM_CMD_PHY_BIT        2
`define CMPM_CMD_WIDTH_LSB      3
`define CMPM_OE_LOW_CYCLES      20
`define CMPM_OE_HIGH_CYCLES     16
`define CMPM_PHY_RESET_CYCLES   17
`define CMPM_PHY_STROBE_CYCLES  4
`endif

// >>> logic/cmpm_pkg.sv
// Types shared by the control memory and PHY port.
`default_nettype none
package cmpm_pkg;
  typedef enum logic [1:0] {CMPM_W_WORD, CMPM_W_HALF_LO, CMPM_W_HALF_HI, CMPM_W_BYTE} cmpm_width_t;
  typedef enum logic [1:0] {CMPM_ST_IDLE, CMPM_ST_MEM, CMPM_ST_PHY, CMPM_ST_DONE} cmpm_state_t;
endpackage
`default_nettype wire

// >>> bench/cmpm_sva.sv
// Pin checker of the control memory and PHY port.
`default_nettype none
module cmpm_sva (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [31:0] cm_data_out,
  input wire logic [3:0]  cm_byte_enable_n,
  input wire logic        cm_output_enable_n,
  input wire logic        cm_write_enable_n,
  input wire logic [3:0]  cm_parity_out,
  input wire logic        phy_chip_select_n,
  input wire logic        phy_read_not_write,
  input wire logic        phy_output_enable_n,
  input wire logic        phy_reset_n
);
  // =====
  // Helpers
  logic [4:0] lo_r;
  logic [4:0] rl_r;
  logic       ph_r;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  always_ff @(posedge sys_clk)
    if (!resetn || cm_output_enable_n) lo_r <= 5'h00;
    else if (lo_r != 5'h1F) lo_r <= lo_r + 5'h01;
  always_ff @(posedge sys_clk)
    if (!resetn || phy_reset_n) rl_r <= 5'h00;
    else if (rl_r != 5'h1F) rl_r <= rl_r + 5'h01;
  // A PHY cycle may cut a read window short, so that window is not judged.
  always_ff @(posedge sys_clk)
    if (!resetn) ph_r <= 1'b0;
    else if (!phy_chip_select_n) ph_r <= 1'b1;
    else if (cm_output_enable_n && lo_r != 5'h00) ph_r <= 1'b0;
  // =====
  // Properties
  property p_oe_win;
    $rose(cm_output_enable_n) && !ph_r && phy_chip_select_n |-> lo_r == 5'h14;
  endproperty
  a_oe_win: assert property (p_oe_win) else $error("read window length wrong");
  property p_we_win;
    !cm_write_enable_n |-> cm_output_enable_n;
  endproperty
  a_we_win: assert property (p_we_win) else $error("write outside write window");
  property p_we_be;
    !cm_write_enable_n |-> cm_byte_enable_n != 4'hF;
  endproperty
  a_we_be: assert property (p_we_be) else $error("write without lanes");
  property p_par;
    !cm_write_enable_n |-> cm_parity_out == {^cm_data_out[31:24], ^cm_data_out[23:16],
                                             ^cm_data_out[15:8], ^cm_data_out[7:0]};
  endproperty
  a_par: assert property (p_par) else $error("write parity wrong");
  property p_phy_mem;
    !phy_chip_select_n |-> cm_output_enable_n && cm_write_enable_n;
  endproperty
  a_phy_mem: assert property (p_phy_mem) else $error("memory strobe in PHY cycle");
  property p_phy_oe;
    !phy_output_enable_n |-> !phy_chip_select_n && phy_read_not_write;
  endproperty
  a_phy_oe: assert property (p_phy_oe) else $error("PHY output enable outside read");
  property p_cs_len;
    $fell(phy_chip_select_n) |-> !phy_chip_select_n [*4] ##1 phy_chip_select_n;
  endproperty
  a_cs_len: assert property (p_cs_len) else $error("PHY select length wrong");
  property p_rst_len;
    $rose(phy_reset_n) |-> rl_r >= 5'h11;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("PHY reset too short");
endmodule
`default_nettype wire

// >>> bench/cmpm_mem_model.sv
// Control memory and PHY register model on the shared lines.
`default_nettype none
module cmpm_mem_model (
  input wire logic        sys_clk,
  input wire logic [18:0] cm_address_bus,
  input wire logic [31:0] cm_data_out,
  input wire logic        cm_data_oe,
  input wire logic [3:0]  cm_byte_enable_n,
  input wire logic        cm_output_enable_n,
  input wire logic        cm_write_enable_n,
  input wire logic [3:0]  cm_parity_out,
  input wire logic        cm_parity_oe,
  input wire logic        phy_chip_select_n,
  input wire logic        phy_read_not_write,
  input wire logic        phy_output_enable_n,
  input wire logic        bad_par,
  output logic     [31:0] cm_data_in,
  output logic     [3:0]  cm_parity_in
);
  logic [31:0] mem [256];
  logic [31:0] phy [16];
  logic [31:0] drv;
  logic [7:0]  a;
  assign a = cm_address_bus[7:0];
  assign cm_data_in = cm_data_oe ? cm_data_out : drv;
  assign cm_parity_in = cm_parity_oe ? cm_parity_out :
    {^drv[31:24], ^drv[23:16], ^drv[15:8], ^drv[7:0] ^ bad_par};
  // Undriven lines fall to zero through the pull-downs; the memory drives only its enabled lanes.
  always_comb
    if (!phy_chip_select_n && !phy_output_enable_n) drv = phy[a[3:0]];
    else if (!cm_output_enable_n) drv = mem[a] & {{8{!cm_byte_enable_n[3]}}, {8{!cm_byte_enable_n[2]}},
      {8{!cm_byte_enable_n[1]}}, {8{!cm_byte_enable_n[0]}}};
    else drv = 32'h0;
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < 4; i++)
      if (!cm_write_enable_n && !cm_byte_enable_n[i]) mem[a][8*i+:8] <= cm_data_in[8*i+:8];
    if (!phy_chip_select_n && !phy_read_not_write) phy[a[3:0]] <= cm_data_in;
  end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench of the control memory and PHY port.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic        phy_irq_n = 1'b1, bad_par = 1'b0, clk_en = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, cm_data_in, cm_data_out, rd_v, d, old, m;
  logic [18:0] cm_address_bus;
  logic [3:0]  cm_byte_enable_n, cm_parity_in, cm_parity_out;
  logic        avs_waitrequest, cm_data_oe, cm_output_enable_n, cm_write_enable_n, cm_parity_oe;
  logic        phy_chip_select_n, phy_read_not_write, phy_output_enable_n, phy_reset_n;
  logic [32:0] exq[$];
  logic [32:0] mq;
  logic [31:0] seed = 32'h3CA604D5;
  int          err_total = 0, checks = 0, rc = 0, rises = 0;
  cmpm_port u_cmpm_port (.sys_clk, .resetn, .clk_en, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .cm_address_bus, .cm_data_in,
    .cm_data_out, .cm_data_oe, .cm_byte_enable_n, .cm_output_enable_n, .cm_write_enable_n,
    .cm_parity_in, .cm_parity_out, .cm_parity_oe, .phy_chip_select_n, .phy_read_not_write,
    .phy_output_enable_n, .phy_irq_n, .phy_reset_n);
  cmpm_mem_model u_cmpm_mem_model (.sys_clk, .cm_address_bus, .cm_data_out, .cm_data_oe,
    .cm_byte_enable_n, .cm_output_enable_n, .cm_write_enable_n, .cm_parity_out, .cm_parity_oe,
    .phy_chip_select_n, .phy_read_not_write, .phy_output_enable_n, .bad_par, .cm_data_in, .cm_parity_in);
  always #10 sys_clk = ~sys_clk;
  // =====
  // Tasks
  function automatic logic [31:0] xs;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic xfer(input bit w, input logic [5:0] a, input logic [31:0] dd, input bit q, input logic [31:0] e);
    if (!w) exq.push_back({q, e});
    avs_address <= a;
    avs_writedata <= dd;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd_v = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic acc(input logic [18:0] a, input logic [31:0] dd, input logic [4:0] c);
    xfer(1, 6'h0C, {13'h0, a}, 0, 0);
    xfer(1, 6'h10, dd, 0, 0);
    xfer(1, 6'h14, {27'h0, c}, 0, 0);
    repeat (200)
    begin
      xfer(0, 6'h04, 0, 0, 0);
      if (rd_v[2] === 1'b0) break;
    end
    chk("access done", {31'h0, rd_v[2]}, 32'h0);
  endtask
  task automatic print_verdict;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // =====
  // Monitors
  always @(posedge sys_clk)
    if (avs_read && avs_waitrequest === 1'b0 && exq.size() > 0)
    begin
      mq = exq.pop_front();
      if (mq[32]) chk("readdata", avs_readdata, mq[31:0]);
    end
  always @(posedge sys_clk)
    if (phy_reset_n === 1'b0 && resetn) rc++;
    else if (phy_reset_n === 1'b1 && rc != 0)
    begin
      chk("phy reset length", {31'h0, rc >= 17}, 1);
      rises++;
      rc = 0;
    end
  initial
  begin
    #400000;
    err_total++;
    print_verdict;
  end
  // =====
  // Scenarios
  initial
  begin
    repeat (6) @(posedge sys_clk);
    chk("phy reset in reset", {31'h0, phy_reset_n}, 0);
    resetn <= 1'b1;
    xfer(0, 6'h00, 0, 1, 0);
    xfer(0, 6'h3C, 0, 1, 0);
    for (int w = 0; w < 4; w++)
    begin
      old = xs();
      d = xs();
      m = w == 0 ? 32'hFFFFFFFF : w == 1 ? 32'h0000FFFF : w == 2 ? 32'hFFFF0000 : 32'h00FF0000;
      acc(19'h00012, old, 5'h01);
      acc(19'h00012, d, {2'(w), 3'h1});
      acc(19'h00012, 0, 5'h03);
      xfer(0, 6'h18, 0, 1, (d & m) | (old & ~m));
    end
    bad_par <= 1'b1;
    acc(19'h00012, 0, 5'h03);
    xfer(0, 6'h04, 0, 1, 0);
    xfer(1, 6'h00, 32'h00008000, 0, 0);
    xfer(0, 6'h00, 0, 1, 32'h00008000);
    acc(19'h00012, 0, 5'h03);
    xfer(0, 6'h04, 0, 1, 32'h2);
    bad_par <= 1'b0;
    xfer(1, 6'h08, 0, 0, 0);
    repeat (30) @(posedge sys_clk);
    xfer(0, 6'h04, 0, 1, 0);
    xfer(0, 6'h00, 0, 1, 0);
    for (int k = 0; k < 3; k++)
    begin
      d = xs();
      acc(19'(k), d, 5'h05);
      acc(19'(k), 0, 5'h07);
      xfer(0, 6'h18, 0, 1, d);
    end
    phy_irq_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    xfer(0, 6'h04, 0, 1, 32'h9);
    phy_irq_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    xfer(0, 6'h04, 0, 1, 32'h1);
    xfer(1, 6'h04, 32'h1, 0, 0);
    xfer(0, 6'h04, 0, 1, 0);
    chk("phy reset pulses", rises, 2);
    print_verdict;
  end
endmodule
bind cmpm_port cmpm_sva u_cmpm_sva (.sys_clk, .resetn, .cm_data_out, .cm_byte_enable_n,
  .cm_output_enable_n, .cm_write_enable_n, .cm_parity_out, .phy_chip_select_n, .phy_read_not_write,
  .phy_output_enable_n, .phy_reset_n);
`default_nettype wire
